/* File: psa_consts.svh */
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH
`define PSA_PAGE_CFG_BIT  7
`define PSA_EA_MSB        15
`define PSA_CORE_PSV_BIT  2
`define PSA_ZERO_BYTE     8'h00
`define PSA_ZERO_WORD     16'h0000
`define PSA_ZERO_ADDR     24'h000000
`define PSA_ZERO_WIDE     24'h000000
`endif

/* File: psa_pkg.sv */
package psa_pkg;
  typedef enum logic [4:0] {
    PSA_IDLE  = 5'h01,
    PSA_TBL   = 5'h02,
    PSA_VIS1  = 5'h04,
    PSA_VIS2  = 5'h08,
    PSA_DONE  = 5'h10
  } psa_state_t;

  typedef enum logic [2:0] {
    PSA_OP_RDL = 3'h0,
    PSA_OP_RDH = 3'h1,
    PSA_OP_WTL = 3'h2,
    PSA_OP_WTH = 3'h3,
    PSA_OP_DRD = 3'h4,
    PSA_OP_DWR = 3'h5
  } psa_op_t;

  typedef struct packed {
    logic        valid;
    psa_op_t     op;
    logic        byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic [7:0]  table_page;
    logic [7:0]  visibility_page;
    logic [15:0] core_control;
  } psa_req_t;

  typedef struct packed {
    psa_state_t  state;
    logic [23:0] addr;
    logic        cfg_space;
    logic        wr;
    logic [1:0]  lane_we;
    logic [23:0] mem_wdata;
    logic        mem_req;
    psa_op_t     op;
    logic        byte_mode;
    logic        bsel;
    logic [15:0] rdata;
    logic        done;
  } psa_regs_t;
endpackage

/* File: psa_program_space_access_unit.sv */
// Behaviour
// - the block joins a 24-bit program memory to a 16-bit data path.
// - table accesses use table_page above the 16-bit effective address.
// - table_page top bit picks user (0) or configuration (1) memory.
// - visibility uses visibility_page above the low 15 address bits.
// - visibility accesses always reach user memory, top address bit zero.
// - visibility ignores address bit 15; it comes from visibility_page bit 0.
// - program words sit two address units apart, matching data words.
// - word-mode table_read_low returns program bits 15..0.
// - byte-mode table_read_low returns upper byte if select is 1, else lower.
// - word-mode table_read_high returns bits 23..16 with high byte zero.
// - byte-mode table_read_high returns zero for the phantom byte.
// - only the high table operations touch program bits 23..16.
// - table reads and high writes work in byte and word sizes; a byte-mode low write zeroes the other low-word byte.
// - the visibility window is read-only and shows only the low word.
// - visibility needs the core_control enable bit and address top bit set.
// - a visibility read takes one extra cycle for its second fetch.
`include "psa_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module psa_program_space_access_unit
  import psa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire psa_req_t    req,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             vis_hit,
  output logic             mem_req,
  output logic [23:0]      mem_addr,
  output logic             mem_cfg_space,
  output logic             mem_wr,
  output logic [1:0]       mem_lane_we,
  output logic [23:0]      mem_wdata,
  input  wire logic [23:0] mem_rdata
);
  psa_regs_t r_ff;
  psa_regs_t nxt_r;
  logic      is_tbl;
  logic      is_vis;
  logic      bsel_in;
  // byte picked from the low program word for byte reads
  logic [15:0] low_pick;

  // decode of the incoming request
  always_comb begin
    is_tbl  = (req.op == PSA_OP_RDL) || (req.op == PSA_OP_RDH) ||
              (req.op == PSA_OP_WTL) || (req.op == PSA_OP_WTH);
    is_vis  = (req.op == PSA_OP_DRD || req.op == PSA_OP_DWR) &&
              req.ea[`PSA_EA_MSB] &&
              req.core_control[`PSA_CORE_PSV_BIT];
    bsel_in = req.ea[0];
  end

  // byte steering shared by table_read_low and window byte reads
  psa_lane_pick #(
    .LANE_W (8)
  ) u_low_pick (
    .word_in  (mem_rdata[15:0]),
    .pick_hi  (r_ff.bsel),
    .word_out (low_pick)
  );

  // next-state logic
  always_comb begin
    // hold everything; pulses drop unless armed again below
    nxt_r         = r_ff;
    nxt_r.done    = 1'b0;
    nxt_r.mem_req = 1'b0;
    case (r_ff.state)
      PSA_IDLE: begin
        if (req.valid && is_tbl) begin
          nxt_r.state     = PSA_TBL;
          nxt_r.op        = req.op;
          nxt_r.byte_mode = req.byte_mode;
          nxt_r.bsel      = bsel_in;
          // word address keeps ea bit 0 as byte select only
          nxt_r.addr      = {req.table_page, req.ea[15:1], 1'b0};
          nxt_r.cfg_space = req.table_page[`PSA_PAGE_CFG_BIT];
          nxt_r.wr        = (req.op == PSA_OP_WTL) ||
                            (req.op == PSA_OP_WTH);
          nxt_r.mem_req   = 1'b1;
          nxt_r.lane_we   = 2'b00;
          nxt_r.mem_wdata = `PSA_ZERO_WIDE;
          if (req.op == PSA_OP_WTL) begin
            // low word lane only
            if (req.byte_mode) begin
              nxt_r.lane_we   = 2'b01;
              nxt_r.mem_wdata = bsel_in ?
                {8'h00, req.wdata[7:0], 8'h00} :
                {16'h0000, req.wdata[7:0]};
            end else begin
              nxt_r.lane_we   = 2'b01;
              nxt_r.mem_wdata = {8'h00, req.wdata};
            end
          end else if (req.op == PSA_OP_WTH) begin
            // only the high write reaches bits 23..16
            nxt_r.lane_we   = (req.byte_mode && bsel_in) ? 2'b00 : 2'b10;
            nxt_r.mem_wdata = {req.wdata[7:0], 16'h0000};
          end
          if (nxt_r.wr && req.byte_mode && req.op == PSA_OP_WTL)
            nxt_r.lane_we = bsel_in ? 2'b01 : 2'b01;
        end else if (req.valid && is_vis && req.op == PSA_OP_DRD) begin
          nxt_r.state     = PSA_VIS1;
          nxt_r.op        = PSA_OP_DRD;
          nxt_r.byte_mode = req.byte_mode;
          nxt_r.bsel      = bsel_in;
          // bit 23 forced low, bit 15 from page bit 0
          nxt_r.addr      = {1'b0, req.visibility_page, req.ea[14:1], 1'b0};
          nxt_r.cfg_space = 1'b0;
          nxt_r.wr        = 1'b0;
          nxt_r.lane_we   = 2'b00;
          nxt_r.mem_wdata = `PSA_ZERO_WIDE; // no stale write data
          nxt_r.mem_req   = 1'b1;
        end else if (req.valid && is_vis) begin
          nxt_r.done  = 1'b1; // write dropped
          nxt_r.rdata = `PSA_ZERO_WORD;
        end
      end
      PSA_TBL: begin
        // answer from the word fetched on entry
        nxt_r.state = PSA_DONE;
        nxt_r.done  = 1'b1;
        nxt_r.wr    = 1'b0;
        nxt_r.lane_we = 2'b00;
        case (r_ff.op)
          PSA_OP_RDL: begin
            if (!r_ff.byte_mode)
              nxt_r.rdata = mem_rdata[15:0];
            else
              nxt_r.rdata = low_pick;
          end
          PSA_OP_RDH: begin
            if (r_ff.byte_mode && r_ff.bsel)
              nxt_r.rdata = `PSA_ZERO_WORD;
            else
              nxt_r.rdata = {`PSA_ZERO_BYTE, mem_rdata[23:16]};
          end
          default: nxt_r.rdata = `PSA_ZERO_WORD;
        endcase
      end
      PSA_VIS1: begin
        // second fetch cycle lengthens the access
        nxt_r.state   = PSA_VIS2;
        nxt_r.mem_req = 1'b1;
      end
      PSA_VIS2: begin
        // the second fetch carries the data word
        nxt_r.state = PSA_DONE;
        nxt_r.done  = 1'b1;
        if (r_ff.byte_mode)
          nxt_r.rdata = low_pick;
        else
          nxt_r.rdata = mem_rdata[15:0]; // low word only
      end
      PSA_DONE: begin
        // one turnaround cycle before the next take
        nxt_r.state = PSA_IDLE;
      end
      default: nxt_r.state = PSA_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '{
        state:     PSA_IDLE,
        addr:      `PSA_ZERO_ADDR,
        cfg_space: 1'b0,
        wr:        1'b0,
        lane_we:   2'b00,
        mem_wdata: `PSA_ZERO_WIDE,
        mem_req:   1'b0,
        op:        PSA_OP_RDL,
        byte_mode: 1'b0,
        bsel:      1'b0,
        rdata:     `PSA_ZERO_WORD,
        done:      1'b0
      };
    end else begin
      r_ff <= nxt_r;
    end
  end

  // handshake outputs, decoded from state and request
  assign req_ready     = (r_ff.state == PSA_IDLE);
  assign rsp_valid     = r_ff.done;
  assign vis_hit       = is_vis;

  // read data from flops
  assign rsp_rdata     = r_ff.rdata;

  // memory side, all registered
  assign mem_req       = r_ff.mem_req;
  assign mem_addr      = r_ff.addr;
  assign mem_cfg_space = r_ff.cfg_space;
  assign mem_wr        = r_ff.wr;
  assign mem_lane_we   = r_ff.lane_we;
  assign mem_wdata     = r_ff.mem_wdata;
endmodule

// picks one half of a word onto the low lane, upper lane zero-filled
module psa_lane_pick #(
  parameter int unsigned LANE_W = 8
) (
  input  wire logic [2*LANE_W-1:0] word_in,
  input  wire logic                pick_hi,
  output logic      [2*LANE_W-1:0] word_out
);
  // the lane left out never leaks into the result
  always_comb begin
    word_out             = '0;
    word_out[LANE_W-1:0] = pick_hi ? word_in[2*LANE_W-1:LANE_W] :
                                     word_in[LANE_W-1:0];
  end
endmodule
`default_nettype wire

/* File: psa_props.sv */
`timescale 1ns/1ps
`default_nettype none
module psa_props
  import psa_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire psa_req_t    req,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic        vis_hit,
  input wire logic        mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_cfg_space,
  input wire logic [23:0] mem_rdata
);
  logic tt;
  logic vr;
  logic vw;
  // taken table reads, window reads and window writes
  assign tt = req.valid && req_ready && req.op inside {PSA_OP_RDL, PSA_OP_RDH};
  assign vr = req.valid && req_ready && vis_hit && req.op == PSA_OP_DRD;
  assign vw = req.valid && req_ready && vis_hit && req.op == PSA_OP_DWR;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TBL_ADDR: assert property (tt |=> mem_req &&
    mem_addr[23:1] == {$past(req.table_page), $past(req.ea[15:1])})
    else $error("table address wrong");
  AST_TBL_SPACE: assert property (tt |=>
    mem_cfg_space == $past(req.table_page[7])) else $error("space wrong");
  AST_VIS_ADDR: assert property (vr |=> !mem_cfg_space &&
    mem_addr[23:1] == {1'b0, $past(req.visibility_page), $past(req.ea[14:1])})
    else $error("window address wrong");
  AST_VIS_TWO: assert property (
    vr |=> mem_req ##1 mem_req ##1 rsp_valid)
    else $error("window read timing wrong");
  AST_VIS_DROP: assert property (vw |=> !mem_req [*3])
    else $error("window write reached memory");
  AST_VIS_GATE: assert property (vis_hit |->
    req.ea[15] && req.core_control[2]) else $error("window gate wrong");
  AST_LOW_WORD: assert property (
    tt && req.op == PSA_OP_RDL && !req.byte_mode
    |-> ##2 rsp_valid && rsp_rdata == $past(mem_rdata[15:0]))
    else $error("low word wrong");
  AST_PHANTOM: assert property (
    tt && req.op == PSA_OP_RDH && req.byte_mode && req.ea[0]
    |-> ##2 rsp_valid && rsp_rdata == 16'h0000)
    else $error("phantom not zero");
endmodule
bind psa_program_space_access_unit psa_props u_props (.clk, .rst_n, .req,
  .req_ready, .rsp_valid, .rsp_rdata, .vis_hit, .mem_req, .mem_addr,
  .mem_cfg_space, .mem_rdata);
`default_nettype wire

/* File: psa_prog_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psa_prog_mem_model (
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_cfg_space,
  output logic      [23:0] mem_rdata
);
  // 24-bit words whose content follows the address, so each fetch is known
  assign mem_rdata = {mem_addr[23:16] ^ {mem_cfg_space, 7'h2a},
                      mem_addr[15:0] ^ 16'hc3a5};
endmodule
`default_nettype wire

/* File: program_space_access_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module program_space_access_unit_tb
  import psa_pkg::*;
;
  logic        clk, rst_n, req_ready, rsp_valid, vis_hit;
  logic        mem_req, mem_cfg_space, mem_wr;
  logic [1:0]  mem_lane_we;
  logic [15:0] rsp_rdata;
  logic [23:0] mem_addr, mem_wdata, mem_rdata;
  psa_req_t    req;
  logic [54:0] st, x;
  int          errors = 0, check_count = 0, cyc = 0;
  psa_program_space_access_unit dut (.clk, .rst_n, .req, .req_ready,
    .rsp_valid, .rsp_rdata, .vis_hit, .mem_req, .mem_addr, .mem_cfg_space,
    .mem_wr, .mem_lane_we, .mem_wdata, .mem_rdata);
  psa_prog_mem_model mem (.mem_addr, .mem_cfg_space, .mem_rdata);
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict;
    end
  end
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[23:16] ^ {a[23], 7'h2a}, a[15:0] ^ 16'hc3a5};
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, then wait a bounded time for the answer
  task automatic run(input psa_op_t op, input logic bm, input logic [15:0] ea,
    input logic [7:0] tp, input logic [7:0] vp, input logic cc,
    output logic got);
    @(posedge clk);
    req <= '{1'b1, op, bm, ea, 16'ha5c3, tp, vp, {13'h0, cc, 2'h0}};
    @(posedge clk);
    req.valid <= 1'b0;
    got = 1'b0;
    #1;
    // strobes stand in the cycle after the take
    st = {vis_hit, req_ready, mem_req, mem_wr, mem_lane_we, mem_wdata,
          mem_cfg_space, mem_addr};
    repeat (5) begin
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        break;
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_table;
    logic g;
    logic [23:0] p;
    logic [15:0] ea, e;
    logic [7:0] tp;
    psa_op_t op;
    for (int i = 0; i < 8; i++) begin
      op = i[1] ? PSA_OP_RDH : PSA_OP_RDL;
      ea = {15'h4d67, i[0]};
      tp = {i[0], 7'h15};
      p = pw({tp, ea[15:1], 1'b0});
      e = op == PSA_OP_RDL ? (i[2] ? {8'h00, ea[0] ? p[15:8] : p[7:0]}
          : p[15:0]) : ((i[2] && ea[0]) ? 16'h0 : {8'h00, p[23:16]});
      run(op, i[2], ea, tp, 8'h00, 1'b0, g);
      check({15'h0, g}, 16'h1);
      check(rsp_rdata, e);
      x = {4'b0010, 2'b00, 24'h0, tp[7], tp, ea[15:1], 1'b0};
      check(st, x);
    end
    run(PSA_OP_WTH, 1'b0, 16'h0124, 8'h03, 8'h00, 1'b0, g);
    check({15'h0, g}, 16'h1);
    $display("table test done");
  endtask
  task automatic t_window;
    logic g;
    logic [23:0] a, p;
    a = {1'b0, 8'h9d, 14'h33c4 >> 1, 1'b0};
    p = pw(a);
    run(PSA_OP_DRD, 1'b0, 16'hb3c4, 8'h81, 8'h9d, 1'b1, g);
    check({15'h0, g}, 16'h1);
    check(rsp_rdata, p[15:0]);
    x = {4'b1010, 2'b00, 24'h0, 1'b0, a};
    check(st, x);
    run(PSA_OP_DRD, 1'b1, 16'hb3c5, 8'h81, 8'h9d, 1'b1, g);
    check(rsp_rdata, {8'h00, p[15:8]});
    run(PSA_OP_DWR, 1'b0, 16'hb3c4, 8'h81, 8'h9d, 1'b1, g);
    check({15'h0, g}, 16'h1);
    check(rsp_rdata, 16'h0000);
    check(st[54:51], 4'b1100);
    run(PSA_OP_DRD, 1'b0, 16'hb3c4, 8'h81, 8'h9d, 1'b0, g);
    check({15'h0, g}, 16'h0);
    check(st[54:53], 2'b01);
    run(PSA_OP_DRD, 1'b0, 16'h33c4, 8'h81, 8'h9d, 1'b1, g);
    check({15'h0, g}, 16'h0);
    check(st[54:53], 2'b01);
    $display("window test done");
  endtask
  task automatic t_write;
    logic g;
    run(PSA_OP_WTL, 1'b0, 16'h0124, 8'h83, 8'h00, 1'b0, g);
    x = {4'b0011, 2'b01, 24'h00a5c3, 1'b1, 24'h830124};
    check(st, x);
    run(PSA_OP_WTL, 1'b1, 16'h0125, 8'h03, 8'h00, 1'b0, g);
    x = {4'b0011, 2'b01, 24'h00c300, 1'b0, 24'h030124};
    check(st, x);
    run(PSA_OP_WTL, 1'b1, 16'h0124, 8'h03, 8'h00, 1'b0, g);
    x = {4'b0011, 2'b01, 24'h0000c3, 1'b0, 24'h030124};
    check(st, x);
    run(PSA_OP_WTH, 1'b0, 16'h0124, 8'h03, 8'h00, 1'b0, g);
    x = {4'b0011, 2'b10, 24'hc30000, 1'b0, 24'h030124};
    check(st, x);
    run(PSA_OP_WTH, 1'b1, 16'h0125, 8'h03, 8'h00, 1'b0, g);
    x = {4'b0011, 2'b00, 24'hc30000, 1'b0, 24'h030124};
    check(st, x);
    check({15'h0, g}, 16'h1);
    $display("write test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    req = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_table;
    t_window;
    t_write;
    give_verdict;
  end
endmodule
`default_nettype wire
